/* core/alu_core.sv */
// Eight-bit arithmetic unit with flag generation.
// Assumes operands are stable in the cycle the result is used.
`include "ptr_flag_params.svh"
module alu_core
  import ptr_flag_pkg::*;
(
  // Operands
  input wire alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  // Results
  output logic [7:0] result,
  output logic carry_out,
  output logic half_out,
  output logic ovf_out,
  output logic arith
);
  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] b_eff;
  logic cin;
  logic c7;
  always_comb
  begin
    b_eff = b;
    cin = 1'b0;
    arith = 1'b1;
    if (op == op_sub || op == op_sbc)
      b_eff = ~b;
    if (op == op_sub)
      cin = 1'b1;
    else if (op == op_adc || op == op_sbc)
      cin = carry_in;
    // Subtract is add of complement: carry out means no borrow
    sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    c7 = a[7] ^ b_eff[7] ^ sum[7];
    result = sum[7:0];
    carry_out = sum[8];
    half_out = low[4];
    ovf_out = c7 ^ sum[8];
    case (op)
      op_and: result = a & b;
      op_or: result = a | b;
      op_xor: result = a ^ b;
      op_rlc: {carry_out, result} = {a, carry_in};
      op_rrc: {result, carry_out} = {carry_in, a};
      op_move: result = b;
      default: ;
    endcase
    if (!(op == op_add || op == op_adc || op == op_sub || op == op_sbc))
      arith = 1'b0;
  end
endmodule

/* core/cpu_pointer_and_flag_regs.sv */
// Pointer, accumulator, program-counter-low, table and status logic.
// Assumes the execution unit issues one operation per enabled cycle and
// owns data memory, which this block addresses on its behalf.
`include "ptr_flag_params.svh"
module cpu_pointer_and_flag_regs
  import ptr_flag_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int SECT_W = 2
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // Operation from the execution unit
  input wire logic op_valid,
  input wire alu_op_t op,
  input wire logic [SECT_W+7:0] mem_addr,
  input wire logic ext_addr,
  input wire logic to_acc,
  input wire logic mem_src,
  input wire logic [7:0] imm_data,
  input wire logic [7:0] mem_rdata,
  // System events
  input wire logic wdt_timeout,
  input wire logic watchdog_clear_instr,
  input wire logic halt_instr,
  // Table read
  input wire logic table_read,
  input wire logic [15:0] prog_word,
  // Program counter
  input wire logic [PC_W-1:0] pc_in,
  // Data memory port
  output logic [SECT_W+7:0] dm_addr,
  output logic dm_we,
  output logic [7:0] dm_wdata,
  // Status to the execution unit
  output logic [PC_W-1:0] pc_jump,
  output logic pc_load,
  output logic dummy_cycle,
  output logic [PC_W-1:0] table_addr,
  output logic [7:0] acc,
  output logic [7:0] alu_condition_flags
);
  //////////////////////////////////////////////////////////////////////
  logic rst1_r;
  logic rst_n_r;
  logic [7:0] sector0_pointer;
  logic [7:0] pointer1_low;
  logic [SECT_W-1:0] pointer1_sector;
  logic [7:0] pointer2_low;
  logic [SECT_W-1:0] pointer2_sector;
  logic [7:0] table_pointer_low;
  logic [7:0] table_pointer_high;
  logic [7:0] table_high_latch;
  logic [7:0] acc_r;
  logic signed_compare_flag, compare_zero_flag, watchdog_timeout_flag;
  logic power_down_flag, overflow_flag, zero_flag, half_carry_flag, carry;
  logic [7:0] sfr_off;
  logic is_sfr;
  logic [7:0] sfr_rdata;
  logic [7:0] operand;
  logic [7:0] result;
  logic c_out, h_out, v_out, arith;
  logic wr_sfr;
  logic [SECT_W+7:0] eff_addr;
  logic dummy_r;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst1_r <= 1'b1;
      rst_n_r <= rst1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Address resolution
  always_comb
  begin
    // Short form names sector 0 until a pointer port redirects it; extended carries the sector
    eff_addr = ext_addr ? mem_addr : {{SECT_W{1'b0}}, mem_addr[7:0]};
    if (eff_addr[SECT_W+7:8] == `ZERO_SECTOR && eff_addr[7:0] == `ADR_IND0)
      eff_addr = {{SECT_W{1'b0}}, sector0_pointer};
    else if (eff_addr[SECT_W+7:8] == `ZERO_SECTOR
             && eff_addr[7:0] == `ADR_IND1)
      eff_addr = {pointer1_sector, pointer1_low};
    else if (eff_addr[SECT_W+7:8] == `ZERO_SECTOR
             && eff_addr[7:0] == `ADR_IND2)
      eff_addr = {pointer2_sector, pointer2_low};
  end

  assign sfr_off = eff_addr[7:0];
  assign is_sfr = eff_addr[SECT_W+7:8] == `ZERO_SECTOR
                  && sfr_off < `SFR_TOP;

  always_comb
  begin
    sfr_rdata = `ZERO_BYTE;
    // Pointer naming a port again lands here and reads zero
    if (sfr_off == `ADR_PTR0)
      sfr_rdata = sector0_pointer;
    else if (sfr_off == `ADR_PTR1L)
      sfr_rdata = pointer1_low;
    else if (sfr_off == `ADR_PTR1H)
      sfr_rdata = {{(8-SECT_W){1'b0}}, pointer1_sector};
    else if (sfr_off == `ADR_PTR2L)
      sfr_rdata = pointer2_low;
    else if (sfr_off == `ADR_PTR2H)
      sfr_rdata = {{(8-SECT_W){1'b0}}, pointer2_sector};
    else if (sfr_off == `ADR_ACC)
      sfr_rdata = acc_r;
    else if (sfr_off == `ADR_PCL)
      sfr_rdata = pc_in[7:0];
    else if (sfr_off == `ADR_TABLE_POINTER_LOW)
      sfr_rdata = table_pointer_low;
    else if (sfr_off == `ADR_TABLE_POINTER_HIGH)
      sfr_rdata = table_pointer_high;
    else if (sfr_off == `ADR_TABLE_HIGH_LATCH)
      sfr_rdata = table_high_latch;
    else if (sfr_off == `ADR_STATUS)
      sfr_rdata = alu_condition_flags;
  end

  assign operand = mem_src ? (is_sfr ? sfr_rdata : mem_rdata) : imm_data;

  alu_core u_alu (
    .op(op),
    .a(acc_r),
    .b(operand),
    .carry_in(carry),
    .result(result),
    .carry_out(c_out),
    .half_out(h_out),
    .ovf_out(v_out),
    .arith(arith)
  );

  // Results reach memory only when not kept in accumulator
  assign wr_sfr = op_valid && !to_acc && !table_read && is_sfr;
  assign dm_addr = eff_addr;
  assign dm_we = clk_en && op_valid && !to_acc && !is_sfr;
  assign dm_wdata = table_read ? prog_word[7:0] : result;
  assign acc = acc_r;
  assign table_addr = PC_W'({table_pointer_high, table_pointer_low});
  assign pc_jump = {pc_in[PC_W-1:8], result};
  assign pc_load = clk_en && wr_sfr && sfr_off == `ADR_PCL;
  assign dummy_cycle = dummy_r;
  assign alu_condition_flags = {signed_compare_flag, compare_zero_flag,
    watchdog_timeout_flag, power_down_flag, overflow_flag, zero_flag,
    half_carry_flag, carry};

  //////////////////////////////////////////////////////////////////////
  // Accumulator, the only path between two registers
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
      acc_r <= `ZERO_BYTE;
    else if (clk_en && op_valid)
    begin
      if (to_acc)
        acc_r <= table_read ? prog_word[7:0] : result;
      else if (wr_sfr && sfr_off == `ADR_ACC)
        acc_r <= result;
    end
  end

  // Pointers and table registers
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      sector0_pointer <= `ZERO_BYTE;
      pointer1_low <= `ZERO_BYTE;
      pointer1_sector <= `ZERO_SECTOR;
      pointer2_low <= `ZERO_BYTE;
      pointer2_sector <= `ZERO_SECTOR;
      table_pointer_low <= `ZERO_BYTE;
      table_pointer_high <= `ZERO_BYTE;
      table_high_latch <= `ZERO_BYTE;
    end
    else if (clk_en)
    begin
      if (op_valid && table_read)
        table_high_latch <= prog_word[15:8];
      if (wr_sfr)
      begin
        // Port addresses reach here only through a pointer and match no branch, so their writes drop
        if (sfr_off == `ADR_PTR0)
          sector0_pointer <= result;
        else if (sfr_off == `ADR_PTR1L)
          pointer1_low <= result;
        else if (sfr_off == `ADR_PTR1H)
          pointer1_sector <= result[SECT_W-1:0];
        else if (sfr_off == `ADR_PTR2L)
          pointer2_low <= result;
        else if (sfr_off == `ADR_PTR2H)
          pointer2_sector <= result[SECT_W-1:0];
        else if (sfr_off == `ADR_TABLE_POINTER_LOW)
          table_pointer_low <= result;
        else if (sfr_off == `ADR_TABLE_POINTER_HIGH)
          table_pointer_high <= result;
      end
    end
  end

  // One dummy cycle after a low-byte jump
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
      dummy_r <= 1'b0;
    else if (clk_en)
      dummy_r <= pc_load ? `DUMMY_CYCLES : 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // System flags: not software writable
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      watchdog_timeout_flag <= 1'b0;
      power_down_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      // Timeout event wins over a clear in the same cycle
      if (wdt_timeout)
        watchdog_timeout_flag <= 1'b1;
      else if (watchdog_clear_instr || halt_instr)
        watchdog_timeout_flag <= 1'b0;
      if (halt_instr)
        power_down_flag <= 1'b1;
      else if (watchdog_clear_instr)
        power_down_flag <= 1'b0;
    end
  end

  // Arithmetic flags; no save on call or interrupt, software's job
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      signed_compare_flag <= 1'b0;
      compare_zero_flag <= 1'b0;
      overflow_flag <= 1'b0;
      zero_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      carry <= 1'b0;
    end
    else if (clk_en && op_valid && !table_read)
    begin
      if (wr_sfr && sfr_off == `ADR_STATUS)
      begin
        {signed_compare_flag, compare_zero_flag} <= result[7:6];
        {overflow_flag, zero_flag, half_carry_flag, carry} <= result[3:0];
      end
      else if (op != op_none && op != op_move)
      begin
        // Same edge as the write-back
        zero_flag <= result == `ZERO_BYTE;
        if (arith)
        begin
          carry <= c_out;
          half_carry_flag <= h_out;
          overflow_flag <= v_out;
          signed_compare_flag <= v_out ^ result[7];
        end
        else if (op == op_rlc || op == op_rrc)
          carry <= c_out;
        if (op == op_sub)
          compare_zero_flag <= result == `ZERO_BYTE;
        else if (op == op_sbc)
          compare_zero_flag <= compare_zero_flag
                               && result == `ZERO_BYTE;
        // Other operations keep compare-zero
      end
    end
  end
endmodule

/* core/ptr_flag_params.svh */
// Constants for the pointer, accumulator and flag block.
// Assumes the execution unit drives one decoded operation per enabled cycle.
`ifndef PTR_FLAG_PARAMS_SVH
`define PTR_FLAG_PARAMS_SVH
`define ADR_IND0 8'h00
`define ADR_PTR0 8'h01
`define ADR_IND1 8'h02
`define ADR_PTR1L 8'h03
`define ADR_PTR1H 8'h04
`define ADR_IND2 8'h05
`define ADR_PTR2L 8'h06
`define ADR_PTR2H 8'h07
`define ADR_ACC 8'h08
`define ADR_PCL 8'h09
`define ADR_TABLE_POINTER_LOW 8'h0A
`define ADR_TABLE_POINTER_HIGH 8'h0B
`define ADR_TABLE_HIGH_LATCH 8'h0C
`define ADR_STATUS 8'h0D
`define SFR_TOP 8'h0E
`define BIT_SC 7
`define BIT_CZ 6
`define BIT_TO 5
`define BIT_PD 4
`define BIT_OV 3
`define BIT_Z 2
`define BIT_AC 1
`define BIT_C 0
`define ZERO_BYTE 8'h00
`define ZERO_SECTOR 2'h0
`define DUMMY_CYCLES 1'b1
`endif

/* core/ptr_flag_pkg.sv */
// Types shared by the pointer and flag block.
// Assumes the execution unit decodes the instruction class.
package ptr_flag_pkg;
  typedef enum logic [3:0] {
    op_none, op_add, op_adc, op_sub, op_sbc, op_and, op_or, op_xor,
    op_rlc, op_rrc, op_move
  } alu_op_t;
endpackage

/* testbench/exec_far_side.sv */
// Data and program memory behind the execution unit.
// Assumes combinational reads at the addresses the block resolves.
module exec_far_side #(
  parameter int PC_W = 13,
  parameter int SECT_W = 2
)
(
  // Clock
  input wire logic clock,
  // Data memory
  input wire logic [SECT_W+7:0] dm_addr,
  input wire logic dm_we,
  input wire logic [7:0] dm_wdata,
  output logic [7:0] mem_rdata,
  // Program memory
  input wire logic [PC_W-1:0] table_addr,
  output logic [15:0] prog_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [2**(SECT_W+8)];
  // Preset nonzero except at offset 5A of each sector, so a missed redirect cannot read back as zero
  initial
    for (int i = 0; i < 2**(SECT_W+8); i++)
      mem[i] = 8'(i) ^ 8'h5A;
  always @(posedge clock)
    if (dm_we)
      mem[dm_addr] <= dm_wdata;
  assign mem_rdata = mem[dm_addr];
  assign prog_word = 16'(table_addr) ^ 16'hA5A5;
endmodule

/* testbench/ptr_flag_sva.sv */
// Port checker for the pointer, accumulator and flag block.
// Assumes it is bound to the block top and sees one clock domain.
module ptr_flag_sva
  import ptr_flag_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int SECT_W = 2
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Operation
  input wire logic clk_en,
  input wire logic op_valid,
  input wire alu_op_t op,
  input wire logic [SECT_W+7:0] mem_addr,
  input wire logic ext_addr,
  input wire logic to_acc,
  // Events
  input wire logic wdt_timeout,
  input wire logic watchdog_clear_instr,
  input wire logic halt_instr,
  // Outputs watched
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [SECT_W+7:0] dm_addr,
  input wire logic [PC_W-1:0] pc_jump,
  input wire logic pc_load,
  input wire logic dummy_cycle,
  input wire logic [7:0] acc,
  input wire logic [7:0] alu_condition_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic go;
  logic ev;
  logic [7:0] f;
  assign go = clk_en && op_valid && to_acc;
  assign ev = clk_en && (wdt_timeout || watchdog_clear_instr || halt_instr);
  assign f = alu_condition_flags;
  sequence dummy_pulse_s;
    dummy_cycle ##1 !dummy_cycle;
  endsequence
  dummy_pulse_a: assert property (pc_load |=> dummy_pulse_s)
    else $error("no single dummy cycle after counter load");
  pc_page_a: assert property (pc_load |-> pc_jump[PC_W-1:8] == pc_in[PC_W-1:8])
    else $error("counter jump left its page");
  sys_hold_a: assert property (!ev |=> $stable(f[5:4]))
    else $error("timeout or power-down moved without event");
  to_set_a: assert property (clk_en && wdt_timeout |=> f[5])
    else $error("timeout flag not set");
  halt_pd_a: assert property (clk_en && halt_instr && !watchdog_clear_instr
    && !wdt_timeout |=> f[5:4] == 2'h1)
    else $error("halt did not set power-down only");
  clear_a: assert property (clk_en && watchdog_clear_instr && !wdt_timeout
    && !halt_instr |=> f[5:4] == 2'h0)
    else $error("watchdog clear left a system flag");
  sc_xor_a: assert property (go && op inside {op_add, op_adc, op_sub, op_sbc}
    |=> f[7] == (f[3] ^ acc[7]))
    else $error("signed compare flag wrong");
  zero_acc_a: assert property (go && op inside {op_add, op_adc, op_sub, op_sbc,
    op_and, op_or, op_xor} |=> f[2] == (acc == 8'h00))
    else $error("zero flag disagrees with result");
  cz_sub_a: assert property (go && op == op_sub |=> f[6] == f[2])
    else $error("compare-zero not equal to zero");
  cz_keep_a: assert property (go && op inside {op_add, op_adc, op_and, op_or,
    op_xor} |=> $stable(f[6]))
    else $error("compare-zero changed");
  sector0_a: assert property (op_valid && !ext_addr && mem_addr[7:0] == 8'h00
    |-> dm_addr[SECT_W+7:8] == '0)
    else $error("port 0 left sector 0");
  ext_map_a: assert property (op_valid && ext_addr && mem_addr[SECT_W+7:8] != '0
    |-> dm_addr == mem_addr)
    else $error("extended address not kept");
endmodule

/* testbench/test_cpu_pointer_and_flag_regs.sv */
// Directed bench for the pointer, accumulator and flag block.
// Assumes the memory model and the checker files compile before it.
module test_cpu_pointer_and_flag_regs;
  import ptr_flag_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC_W = 13;
  localparam int SECT_W = 2;
  logic clock = 0, reset_n = 0, clk_en = 1, op_valid = 0, ext_addr = 0;
  logic to_acc = 0, mem_src = 0, table_read = 0, wdt_timeout = 0;
  logic watchdog_clear_instr = 0, halt_instr = 0, dm_we, pc_load, dummy_cycle;
  alu_op_t op = op_none;
  logic [SECT_W+7:0] mem_addr = '0, dm_addr;
  logic [7:0] imm_data = 8'h00, mem_rdata, dm_wdata, acc, alu_condition_flags;
  logic [15:0] prog_word;
  logic [PC_W-1:0] pc_in = 13'h1A55, pc_jump, table_addr;
  int n_fail = 0, tests_run = 0;
  cpu_pointer_and_flag_regs #(.PC_W(PC_W), .SECT_W(SECT_W)) i_dut (
    .clock, .reset_n, .clk_en, .op_valid, .op, .mem_addr, .ext_addr, .to_acc,
    .mem_src, .imm_data, .mem_rdata, .wdt_timeout, .watchdog_clear_instr,
    .halt_instr, .table_read, .prog_word, .pc_in, .dm_addr, .dm_we, .dm_wdata,
    .pc_jump, .pc_load, .dummy_cycle, .table_addr, .acc, .alu_condition_flags);
  exec_far_side #(.PC_W(PC_W), .SECT_W(SECT_W)) i_far (
    .clock, .dm_addr, .dm_we, .dm_wdata, .mem_rdata, .table_addr, .prog_word);
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      n_fail++;
    end
  endtask
  task automatic issue(alu_op_t o, logic [9:0] a, logic e, logic t, logic s,
    logic [7:0] d);
    @(posedge clock);
    op_valid <= 1'b1;
    op <= o;
    mem_addr <= a;
    ext_addr <= e;
    to_acc <= t;
    mem_src <= s;
    imm_data <= d;
    #10;
  endtask
  // Clears strobes and events; results of the last edge are settled
  task automatic idle;
    @(posedge clock);
    op_valid <= 1'b0;
    table_read <= 1'b0;
    wdt_timeout <= 1'b0;
    watchdog_clear_instr <= 1'b0;
    halt_instr <= 1'b0;
    clk_en <= 1'b1;
    #10;
  endtask
  task automatic run(alu_op_t o, logic [7:0] d);
    issue(o, 10'h000, 1'b0, 1'b1, 1'b0, d);
    idle;
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    issue(op_move, a, 1'b0, 1'b0, 1'b0, d);
    idle;
  endtask
  task automatic rd(logic [9:0] a);
    issue(op_move, a, 1'b0, 1'b1, 1'b1, 8'h00);
    idle;
  endtask
  task automatic pulse(logic h, logic w, logic c);
    @(posedge clock);
    halt_instr <= h;
    wdt_timeout <= w;
    watchdog_clear_instr <= c;
    idle;
  endtask
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    #10;
    check(alu_condition_flags, 8'h00);
    run(op_move, 8'h7F);
    run(op_add, 8'h01);
    check(acc, 8'h80);
    check(alu_condition_flags, 8'h0A);
    run(op_sub, 8'h80);
    check(alu_condition_flags, 8'h47);
    run(op_sbc, 8'h01);
    check(alu_condition_flags, 8'h80);
    run(op_and, 8'h00);
    check(alu_condition_flags, 8'h84);
    @(posedge clock);
    clk_en <= 1'b0;
    run(op_move, 8'h33);
    check(acc, 8'h00);
    $display("test done: flags");
    wr(10'h00D, 8'hFF);
    check(alu_condition_flags, 8'hCF);
    pulse(1'b0, 1'b1, 1'b0);
    check(alu_condition_flags[5:4], 2'h2);
    pulse(1'b1, 1'b0, 1'b0);
    check(alu_condition_flags[5:4], 2'h1);
    pulse(1'b0, 1'b0, 1'b1);
    check(alu_condition_flags[5:4], 2'h0);
    $display("test done: system flags");
    // Pointer aims at plain memory; a port offset would be refused
    wr(10'h001, 8'h40);
    rd(10'h001);
    check(acc, 8'h40);
    issue(op_move, 10'h000, 1'b0, 1'b0, 1'b0, 8'hAA);
    check(dm_addr, 10'h040);
    check(dm_we, 1'b1);
    idle;
    rd(10'h000);
    check(acc, 8'hAA);
    wr(10'h003, 8'hF0);
    wr(10'h004, 8'h01);
    issue(op_move, 10'h002, 1'b0, 1'b0, 1'b0, 8'h00);
    check(dm_addr, 10'h1F0);
    wr(10'h006, 8'h40);
    wr(10'h007, 8'h02);
    issue(op_move, 10'h005, 1'b0, 1'b0, 1'b0, 8'h00);
    check(dm_addr, 10'h240);
    issue(op_move, 10'h1F0, 1'b1, 1'b0, 1'b0, 8'h00);
    check(dm_addr, 10'h1F0);
    issue(op_move, 10'h1F0, 1'b0, 1'b0, 1'b0, 8'h00);
    check(dm_addr, 10'h0F0);
    wr(10'h001, 8'h00);
    issue(op_move, 10'h000, 1'b0, 1'b0, 1'b0, 8'h11);
    check(dm_we, 1'b0);
    idle;
    rd(10'h000);
    check(acc, 8'h00);
    $display("test done: pointers");
    issue(op_move, 10'h009, 1'b0, 1'b0, 1'b0, 8'h34);
    check(pc_load, 1'b1);
    check(pc_jump, 13'h1A34);
    idle;
    check(dummy_cycle, 1'b1);
    wr(10'h00A, 8'h21);
    wr(10'h00B, 8'h03);
    check(table_addr, 13'h0321);
    @(posedge clock);
    table_read <= 1'b1;
    issue(op_move, 10'h040, 1'b0, 1'b0, 1'b1, 8'h00);
    check(dm_wdata, 8'h84);
    idle;
    rd(10'h00C);
    check(acc, 8'hA6);
    $display("test done: counter and table");
    final_report;
  end
  initial
  begin
    #500000;
    n_fail++;
    final_report;
  end
endmodule
bind cpu_pointer_and_flag_regs ptr_flag_sva #(.PC_W(PC_W), .SECT_W(SECT_W))
  i_sva (.clock, .reset_n, .clk_en, .op_valid, .op, .mem_addr, .ext_addr,
  .to_acc, .wdt_timeout, .watchdog_clear_instr, .halt_instr, .pc_in, .dm_addr,
  .pc_jump, .pc_load, .dummy_cycle, .acc, .alu_condition_flags);
